// ---- logic/cfgio_core.sv ----
// configuration and digital i/o function logic of the control module
//
// Local design decisions: the placing of the registers and the strobed register port.
`default_nettype none
`include "cfgio_regs.svh"

// Behaviour
// [RULE1] hold set: restore pre-power-loss run state
// [RULE2] hold clear: always start stopped
// [RULE3] completion flag kept or cleared by hold
// [RULE4] mains setting: 0 is 50 Hz, 1 is 60 Hz
// [RULE5] receive-to-send gap 0..255 ms, default 0
// [RULE6] output carries source chosen by code 0..8
// [RULE7] reduced variant: outputs 3 and 4 ignored
// [RULE8] input function: none, 8, run+4, run+ilk+2
// [RULE9] three-bit input use mask, default 7
// [RULE10] area is one plus binary contact value
// [RULE11] sequencer allows for contact settle delay
// [RULE12] mode 2/3 contact mapping is configurable
module cfgio_core #(
    parameter int unsigned MS_CYCLES = `CFGIO_GAP_UNIT_US * `CFGIO_CLK_MHZ
) (
    input  wire logic                     ref_clk_in,
    input  wire logic                     reset_n_in,
    input  wire logic [`CFGIO_ADDR_W-1:0] addr_in,
    input  wire logic [31:0]              wdata_in,
    input  wire logic                     wr_in,
    input  wire logic                     rd_in,
    output logic      [31:0]              rdata_out,
    input  wire logic                     retained_run_in,
    input  wire logic                     reduced_variant_in,
    input  wire logic                     pv_in_range_in,
    input  wire logic                     rise_restart_in,
    input  wire logic                     alarm1_in,
    input  wire logic                     alarm2_in,
    input  wire logic                     burnout_in,
    input  wire logic                     heater_break_alarm_in,
    input  wire logic                     ai_alarm1_in,
    input  wire logic                     ai_alarm2_in,
    input  wire logic                     loop_break_alarm_in,
    input  wire logic                     contact_input_1_in,
    input  wire logic                     contact_input_2_in,
    input  wire logic                     contact_input_3_in,
    input  wire logic                     rx_end_in,
    output logic                          tx_permit_out,
    output logic                          run_state_out,
    output logic                          rise_complete_out,
    output logic                          mains_60hz_out,
    output logic      [3:0]               memory_area_out,
    output logic                          interlock_release_out,
    output logic                          alarm_output_1_out,
    output logic                          alarm_output_2_out,
    output logic                          alarm_output_3_out,
    output logic                          alarm_output_4_out,
    output logic                          irq_out
);
    localparam logic [9:0]  SETTLE_LAST = 10'(`CFGIO_SETTLE_CYC - 1);
    localparam logic [16:0] MS_LAST     = 17'(MS_CYCLES - 1);

    cfgio_pkg::cfgio_state_t r;
    cfgio_pkg::cfgio_state_t n;

    logic [2:0] raw;
    logic [3:0] cv;
    logic [8:0] src;
    logic [3:0] fn;
    logic [1:0] a_lo;
    logic [1:0] a_hi;
    logic [1:0] rest;
    logic [3:0] ev;
    logic       wr_cfg;

    always_comb begin
        n = r;
        ev = 4'h0;
        fn = 4'h0;
        wr_cfg = wr_in;
        n.started = 1'b1;
        // straps caught in the first cycle after release, never under the async reset
        if (!r.started) begin
            n.reduced = reduced_variant_in;
            n.run = r.run_hold ? retained_run_in : 1'b0; // [RULE1] [RULE2]
        end

        // register writes
        if (wr_cfg) begin
            case (addr_in)
                `CFGIO_CFG_OFS: begin
                    n.run_hold = wdata_in[`CFGIO_CFG_RUN_HOLD];
                    n.trc_hold = wdata_in[`CFGIO_CFG_TRC_HOLD];
                    n.mains_60 = wdata_in[`CFGIO_CFG_MAINS_60]; // [RULE4]
                end
                `CFGIO_GAP_OFS:   n.gap_ms = wdata_in[7:0];
                `CFGIO_OUTFN_OFS: n.out_fn = wdata_in[15:0];
                `CFGIO_INFN_OFS: begin
                    n.in_fn   = wdata_in[`CFGIO_INFN_SEL_LSB +: 2];
                    n.in_mask = wdata_in[`CFGIO_INFN_MASK_LSB +: 3];
                    n.run_idx = wdata_in[`CFGIO_INFN_RUNIDX_LSB +: 2];
                    n.ilk_idx = wdata_in[`CFGIO_INFN_ILKIDX_LSB +: 2];
                end
                `CFGIO_AREA_OFS:    n.sw_area = wdata_in[2:0];
                `CFGIO_IRQ_EN_OFS:  n.irq_en = wdata_in[3:0];
                default: ;
            endcase
        end

        // unused inputs read as open before settling
        raw = {contact_input_3_in, contact_input_2_in, contact_input_1_in} & r.in_mask; // [RULE9]
        // contacts must hold a new level for the settle time before they act
        for (int i = 0; i < 3; i++) begin
            if (raw[i] == r.contact[i]) begin
                n.db_cnt[i] = 10'h000;
            end else if (r.db_cnt[i] == SETTLE_LAST) begin
                n.db_cnt[i] = 10'h000;
                n.contact[i] = raw[i]; // [RULE11]
            end else begin
                n.db_cnt[i] = r.db_cnt[i] + 10'h001;
            end
        end
        cv = {1'b0, r.contact & r.in_mask}; // [RULE9]

        // contacts not used for run or interlock carry area bits, low index first
        a_lo = (r.run_idx == 2'h0) ? 2'h1 : 2'h0; // [RULE12]
        a_hi = (r.run_idx == 2'h2) ? 2'h1 : 2'h2; // [RULE12]
        rest = 2'h3 - r.run_idx - r.ilk_idx;       // [RULE12]

        case (r.in_fn) // [RULE8]
            `CFGIO_INFN_AREA8: begin
                n.area = 4'h1 + {1'b0, cv[2:0]}; // [RULE10]
            end
            `CFGIO_INFN_RUN_AREA4: begin
                n.area = 4'h1 + {2'b00, cv[a_hi], cv[a_lo]};
                if (r.started) begin
                    n.run = cv[r.run_idx];
                end
            end
            `CFGIO_INFN_RUN_ILK2: begin
                n.area = 4'h1 + {3'b000, cv[rest]};
                if (r.started) begin
                    n.run = cv[r.run_idx];
                end
            end
            default: begin
                n.area = 4'h1 + {1'b0, r.sw_area};
            end
        endcase
        // software run control only where contacts do not own it
        if (wr_cfg && addr_in == `CFGIO_CTRL_OFS && r.started && !r.in_fn[1]) begin
            n.run = wdata_in[`CFGIO_CTRL_RUN];
        end
        n.ilk_q = cv[r.ilk_idx];
        n.ilk_pulse = (r.in_fn == `CFGIO_INFN_RUN_ILK2) && cv[r.ilk_idx] && !r.ilk_q; // [RULE12]

        // completion flag; restart begins a new rise
        if (rise_restart_in) begin
            n.rise_flag = 1'b0;
        end else if (pv_in_range_in) begin
            n.rise_flag = 1'b1;
        end else if (!r.trc_hold) begin
            n.rise_flag = 1'b0; // [RULE3]
        end

        // alarm output routing; codes above 8 drive nothing
        src = {loop_break_alarm_in, ai_alarm2_in, ai_alarm1_in, r.rise_flag,
               heater_break_alarm_in, burnout_in, alarm2_in, alarm1_in, 1'b0};
        for (int i = 0; i < 4; i++) begin
            fn = r.out_fn[4*i +: 4];
            n.alarm_out[i] = (fn <= `CFGIO_OUTFN_MAX) ? src[fn] : 1'b0; // [RULE6]
            if (i >= 2 && r.reduced) begin
                n.alarm_out[i] = 1'b0; // [RULE7]
            end
        end

        // turnaround gap after each received frame, counted in whole ms
        case (r.gap_state)
            cfgio_pkg::CFGIO_GAP_PERMIT: begin
                if (rx_end_in && r.gap_ms != 8'h00) begin
                    n.gap_state = cfgio_pkg::CFGIO_GAP_WAIT; // [RULE5]
                    n.gap_left = r.gap_ms;
                    n.ms_cnt = 17'h00000;
                end
            end
            cfgio_pkg::CFGIO_GAP_WAIT: begin
                if (rx_end_in) begin
                    n.gap_left = r.gap_ms; // a new frame restarts the gap
                    n.ms_cnt = 17'h00000;
                end else if (r.ms_cnt == MS_LAST) begin
                    n.ms_cnt = 17'h00000;
                    n.gap_left = r.gap_left - 8'h01;
                    if (r.gap_left == 8'h01) begin
                        n.gap_state = cfgio_pkg::CFGIO_GAP_PERMIT; // [RULE5]
                    end
                end else begin
                    n.ms_cnt = r.ms_cnt + 17'h00001;
                end
            end
            default: n.gap_state = cfgio_pkg::CFGIO_GAP_PERMIT;
        endcase

        // interrupt events; a set in the clear cycle wins
        ev[`CFGIO_IRQ_RISE] = n.rise_flag && !r.rise_flag;
        ev[`CFGIO_IRQ_RUN]  = r.started && (n.run != r.run);
        ev[`CFGIO_IRQ_AREA] = r.started && (n.area != r.area);
        ev[`CFGIO_IRQ_ILK]  = n.ilk_pulse;
        n.irq_stat = r.irq_stat;
        if (wr_cfg && addr_in == `CFGIO_IRQ_CLR_OFS) begin
            n.irq_stat = r.irq_stat & ~wdata_in[3:0];
        end
        n.irq_stat = n.irq_stat | ev;
        n.irq = |(n.irq_stat & n.irq_en);

        // read data stands only in the cycle after the strobe
        n.rdata = 32'h0000_0000;
        if (rd_in) begin
            case (addr_in)
                `CFGIO_CFG_OFS:      n.rdata = {29'h0, r.mains_60, r.trc_hold, r.run_hold};
                `CFGIO_CTRL_OFS:     n.rdata = {31'h0, r.run};
                `CFGIO_GAP_OFS:      n.rdata = {24'h0, r.gap_ms};
                `CFGIO_OUTFN_OFS:    n.rdata = {16'h0, r.out_fn};
                `CFGIO_INFN_OFS:     n.rdata = {20'h0, r.ilk_idx, r.run_idx, 1'b0, r.in_mask, 2'h0, r.in_fn};
                `CFGIO_AREA_OFS:     n.rdata = {29'h0, r.sw_area};
                `CFGIO_STATUS_OFS:   n.rdata = {19'h0, r.gap_state == cfgio_pkg::CFGIO_GAP_PERMIT, r.reduced,
                                                r.contact, r.area, 2'h0, r.rise_flag, r.run};
                `CFGIO_IRQ_STAT_OFS: n.rdata = {28'h0, r.irq_stat};
                `CFGIO_IRQ_EN_OFS:   n.rdata = {28'h0, r.irq_en};
                default:             n.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            r <= '0;
            r.run_hold <= `CFGIO_RUN_HOLD_RST;
            r.trc_hold <= `CFGIO_TRC_HOLD_RST;
            r.mains_60 <= `CFGIO_MAINS_60_RST;
            r.gap_ms <= `CFGIO_GAP_RST;
            r.out_fn <= `CFGIO_OUTFN_RST;
            r.in_fn <= `CFGIO_INFN_SEL_RST;
            r.in_mask <= `CFGIO_INFN_MASK_RST;
            r.run_idx <= `CFGIO_RUNIDX_RST;
            r.ilk_idx <= `CFGIO_ILKIDX_RST;
            r.area <= 4'h1;
            r.gap_state <= cfgio_pkg::CFGIO_GAP_PERMIT;
        end else begin
            r <= n;
        end
    end

    assign rdata_out             = r.rdata;
    assign tx_permit_out         = (r.gap_state == cfgio_pkg::CFGIO_GAP_PERMIT);
    assign run_state_out         = r.run;
    assign rise_complete_out     = r.rise_flag;
    assign mains_60hz_out        = r.mains_60;
    assign memory_area_out       = r.area;
    assign interlock_release_out = r.ilk_pulse;
    assign alarm_output_1_out    = r.alarm_out[0];
    assign alarm_output_2_out    = r.alarm_out[1];
    assign alarm_output_3_out    = r.alarm_out[2];
    assign alarm_output_4_out    = r.alarm_out[3];
    assign irq_out               = r.irq;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);

    // judged one edge after the load, so the release edge itself is never taken for it
    property p_restore_run;
        ($rose(r.started) && $past(r.run_hold)) |-> (run_state_out == $past(retained_run_in));
    endproperty
    a_restore_run: assert property (p_restore_run) else $error("run state not restored"); // [RULE1]

    property p_start_stopped;
        ($rose(r.started) && !$past(r.run_hold)) |-> !run_state_out;
    endproperty
    a_start_stopped: assert property (p_start_stopped) else $error("run not stopped at start"); // [RULE2]

    property p_trc_release;
        (rise_complete_out && !pv_in_range_in && !r.trc_hold && !rise_restart_in) |=> !rise_complete_out;
    endproperty
    a_trc_release: assert property (p_trc_release) else $error("completion flag not cleared"); // [RULE3]

    property p_trc_keep;
        (rise_complete_out && r.trc_hold && !rise_restart_in) |=> rise_complete_out;
    endproperty
    a_trc_keep: assert property (p_trc_keep) else $error("completion flag lost under hold"); // [RULE3]

    property p_mains_write;
        (wr_in && addr_in == `CFGIO_CFG_OFS) |=> (mains_60hz_out == $past(wdata_in[`CFGIO_CFG_MAINS_60]));
    endproperty
    a_mains_write: assert property (p_mains_write) else $error("mains setting not taken"); // [RULE4]

    property p_gap_start;
        (rx_end_in && tx_permit_out) |=> (tx_permit_out == ($past(r.gap_ms) == 8'h00));
    endproperty
    a_gap_start: assert property (p_gap_start) else $error("turnaround gap wrong"); // [RULE5]

    property p_out_burnout;
        (r.out_fn[3:0] == 4'h3) |=> (alarm_output_1_out == $past(burnout_in));
    endproperty
    a_out_burnout: assert property (p_out_burnout) else $error("output 1 source wrong"); // [RULE6]

    property p_out_unused;
        (r.out_fn[7:4] == 4'h0) |=> !alarm_output_2_out;
    endproperty
    a_out_unused: assert property (p_out_unused) else $error("unused output driven"); // [RULE6]

    property p_reduced;
        r.reduced |=> (!alarm_output_3_out && !alarm_output_4_out);
    endproperty
    a_reduced: assert property (p_reduced) else $error("reduced variant drives output 3 or 4"); // [RULE7]

    property p_area8;
        (r.in_fn == `CFGIO_INFN_AREA8) |=> (memory_area_out == 4'h1 + {1'b0, $past(r.contact & r.in_mask)});
    endproperty
    a_area8: assert property (p_area8) else $error("eight-area decode wrong"); // [RULE10]

    property p_mask;
        (r.in_fn == `CFGIO_INFN_AREA8 && !r.in_mask[0]) |=> memory_area_out[0];
    endproperty
    a_mask: assert property (p_mask) else $error("masked input used"); // [RULE9]

    property p_mode0_area;
        (r.in_fn == `CFGIO_INFN_NONE) |=> (memory_area_out == 4'h1 + {1'b0, $past(r.sw_area)});
    endproperty
    a_mode0_area: assert property (p_mode0_area) else $error("contacts act with no function"); // [RULE8]

    property p_ilk_pulse;
        interlock_release_out |=> !interlock_release_out;
    endproperty
    a_ilk_pulse: assert property (p_ilk_pulse) else $error("interlock release not one cycle"); // [RULE12]

    c_gap_wait: cover property (rx_end_in && r.gap_ms != 8'h00 ##1 !tx_permit_out);
    c_area8: cover property (r.in_fn == `CFGIO_INFN_AREA8 && memory_area_out == 4'h8);
    c_ilk: cover property (interlock_release_out);
    c_irq: cover property (irq_out);
endmodule // cfgio_core
`default_nettype wire

// ---- logic/cfgio_regs.svh ----
// register map, field positions, reset values and timing counts of the i/o function block
`ifndef CFGIO_REGS_SVH
`define CFGIO_REGS_SVH

`define CFGIO_ADDR_W          8
`define CFGIO_CLK_MHZ         100
// register offsets (byte addresses)
`define CFGIO_CFG_OFS         8'h00
`define CFGIO_CTRL_OFS        8'h04
`define CFGIO_GAP_OFS         8'h08
`define CFGIO_OUTFN_OFS       8'h0c
`define CFGIO_INFN_OFS        8'h10
`define CFGIO_AREA_OFS        8'h14
`define CFGIO_STATUS_OFS      8'h18
`define CFGIO_IRQ_STAT_OFS    8'h1c
`define CFGIO_IRQ_CLR_OFS     8'h20
`define CFGIO_IRQ_EN_OFS      8'h24
// CFG fields
`define CFGIO_CFG_RUN_HOLD    0
`define CFGIO_CFG_TRC_HOLD    1
`define CFGIO_CFG_MAINS_60    2
// CTRL fields
`define CFGIO_CTRL_RUN        0
// INFN fields
`define CFGIO_INFN_SEL_LSB    0
`define CFGIO_INFN_MASK_LSB   4
`define CFGIO_INFN_RUNIDX_LSB 8
`define CFGIO_INFN_ILKIDX_LSB 10
// reset values
`define CFGIO_RUN_HOLD_RST    1'b1
`define CFGIO_TRC_HOLD_RST    1'b1
`define CFGIO_MAINS_60_RST    1'b0
`define CFGIO_GAP_RST         8'h00
`define CFGIO_OUTFN_RST       16'h0000
`define CFGIO_INFN_SEL_RST    2'h0
`define CFGIO_INFN_MASK_RST   3'h7
`define CFGIO_RUNIDX_RST      2'h0
`define CFGIO_ILKIDX_RST      2'h1
// input function codes
`define CFGIO_INFN_NONE       2'h0
`define CFGIO_INFN_AREA8      2'h1
`define CFGIO_INFN_RUN_AREA4  2'h2
`define CFGIO_INFN_RUN_ILK2   2'h3
// output function code ceiling
`define CFGIO_OUTFN_MAX       4'h8
// interrupt bits
`define CFGIO_IRQ_RISE        0
`define CFGIO_IRQ_RUN         1
`define CFGIO_IRQ_AREA        2
`define CFGIO_IRQ_ILK         3
// timing
`define CFGIO_GAP_UNIT_US     1000
`define CFGIO_SETTLE_NS       10000
`define CFGIO_SETTLE_CYC      ((`CFGIO_SETTLE_NS * `CFGIO_CLK_MHZ + 999) / 1000)

`endif

// ---- logic/cfgio_pkg.sv ----
// types of the i/o function block
`default_nettype none
package cfgio_pkg;
    typedef enum logic {
        CFGIO_GAP_PERMIT,
        CFGIO_GAP_WAIT
    } cfgio_gap_state_t;

    typedef struct packed {
        logic                   started;
        logic                   reduced;
        logic                   run_hold;
        logic                   trc_hold;
        logic                   mains_60;
        logic [7:0]             gap_ms;
        logic [15:0]            out_fn;
        logic [1:0]             in_fn;
        logic [2:0]             in_mask;
        logic [1:0]             run_idx;
        logic [1:0]             ilk_idx;
        logic [2:0]             sw_area;
        logic                   run;
        logic                   rise_flag;
        logic [3:0]             area;
        logic [2:0]             contact;
        logic [2:0][9:0]        db_cnt;
        logic                   ilk_q;
        logic                   ilk_pulse;
        cfgio_gap_state_t       gap_state;
        logic [7:0]             gap_left;
        logic [16:0]            ms_cnt;
        logic [3:0]             alarm_out;
        logic [3:0]             irq_stat;
        logic [3:0]             irq_en;
        logic                   irq;
        logic [31:0]            rdata;
    } cfgio_state_t;
endpackage : cfgio_pkg
`default_nettype wire

// ---- testbench/cfgio_contact_model.sv ----
// contact or sequencer model that drives the three digital inputs
`default_nettype none
module cfgio_contact_model (
    input  wire logic       clk_in,
    input  wire logic [2:0] target_in,
    output logic            contact_1_out,
    output logic            contact_2_out,
    output logic            contact_3_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [2:0] held_reg   = 3'h0;
    logic [3:0] bounce_reg = 4'h0;

    // real contacts chatter after a move; the chatter stays far below the settle time
    always @(posedge clk_in) begin
        if (target_in != held_reg) begin
            held_reg   <= target_in;
            bounce_reg <= 4'h8;
        end else if (bounce_reg != 4'h0) begin
            bounce_reg <= bounce_reg - 4'h1;
        end
    end

    // the sequencer side only trusts a contact once the chatter has died out
    assign {contact_3_out, contact_2_out, contact_1_out} =
        (bounce_reg != 4'h0 && bounce_reg[0]) ? ~held_reg : held_reg;
endmodule // cfgio_contact_model
`default_nettype wire

// ---- testbench/cfgio_core_tb.sv ----
// self-checking bench of the i/o function block
`default_nettype none
`include "cfgio_regs.svh"
module cfgio_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned MS_CYC = 4;
    logic        ref_clk_in, reset_n_in, wr_in, rd_in, retained_run_in, reduced_variant_in;
    logic        pv_in_range_in, rise_restart_in, rx_end_in, tx_permit_out, irq_out;
    logic        contact_input_1_in, contact_input_2_in, contact_input_3_in;
    logic        run_state_out, rise_complete_out, mains_60hz_out, interlock_release_out;
    logic [7:0]  addr_in;
    logic [31:0] wdata_in, rdata_out, rd_val;
    logic [3:0]  memory_area_out, dout;
    logic [6:0]  src_v;
    logic [2:0]  target;
    integer      error_cnt, tests_run, seed, pulses, n, i, k;

    cfgio_core #(.MS_CYCLES(MS_CYC)) i_dut (
        .ref_clk_in, .reset_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
        .retained_run_in, .reduced_variant_in, .pv_in_range_in, .rise_restart_in,
        .alarm1_in(src_v[0]), .alarm2_in(src_v[1]), .burnout_in(src_v[2]), .heater_break_alarm_in(src_v[3]),
        .ai_alarm1_in(src_v[4]), .ai_alarm2_in(src_v[5]), .loop_break_alarm_in(src_v[6]),
        .contact_input_1_in, .contact_input_2_in, .contact_input_3_in, .rx_end_in, .tx_permit_out,
        .run_state_out, .rise_complete_out, .mains_60hz_out, .memory_area_out, .interlock_release_out,
        .alarm_output_1_out(dout[0]), .alarm_output_2_out(dout[1]), .alarm_output_3_out(dout[2]),
        .alarm_output_4_out(dout[3]), .irq_out
    );

    cfgio_contact_model i_contacts (
        .clk_in(ref_clk_in), .target_in(target), .contact_1_out(contact_input_1_in),
        .contact_2_out(contact_input_2_in), .contact_3_out(contact_input_3_in)
    );

    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cycles(input int c);
        repeat (c) @(posedge ref_clk_in);
        #1;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        wr_in    <= 1'b1;
        addr_in  <= a;
        wdata_in <= d;
        @(posedge ref_clk_in);
        wr_in    <= 1'b0;
        #1;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a);
        @(posedge ref_clk_in);
        rd_in   <= 1'b1;
        addr_in <= a;
        @(posedge ref_clk_in);
        rd_in   <= 1'b0;
        #1;
        rd_val = rdata_out;
    endtask

    task automatic do_reset(input logic r);
        @(posedge ref_clk_in);
        retained_run_in    <= r;
        reduced_variant_in <= r;
        reset_n_in         <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
        reset_n_in <= 1'b1;
        cycles(3);
    endtask

    // settle wait covers chatter plus the debounce count
    task automatic set_contacts(input logic [2:0] t);
        @(posedge ref_clk_in);
        target <= t;
        pulses = 0;
        repeat (1020) begin
            @(posedge ref_clk_in);
            #1;
            if (interlock_release_out === 1'b1) pulses++;
        end
    endtask

    function automatic logic exp_out(input logic [3:0] code, input logic [6:0] s, input logic rise);
        logic [7:0] v;
        v = {s[6:4], rise, s[3:0]};
        if (code == 4'h0 || code > 4'h8) return 1'b0;
        return v[code - 4'h1];
    endfunction

    initial begin
        repeat (100000) @(posedge ref_clk_in);
        error_cnt++;
        $display("Error watchdog expected finish seen hang");
        complete_run();
    end

    initial begin
        seed = 32'h34ea;
        error_cnt = 0;
        tests_run = 0;
        reset_n_in = 1'b0;
        wr_in = 1'b0;
        rd_in = 1'b0;
        addr_in = 8'h00;
        wdata_in = 32'h0;
        retained_run_in = 1'b0;
        reduced_variant_in = 1'b0;
        pv_in_range_in = 1'b0;
        rise_restart_in = 1'b0;
        rx_end_in = 1'b0;
        src_v = 7'h00;
        target = 3'h0;
        for (i = 0; i < 2; i++) begin
            do_reset(i[0]);
            chk_bit("run_state", i[0], run_state_out);
            reg_rd(`CFGIO_CFG_OFS);
            chk_word("cfg", 32'h3, rd_val);
            reg_rd(`CFGIO_GAP_OFS);
            chk_word("gap", 32'h0, rd_val);
            reg_rd(`CFGIO_INFN_OFS);
            chk_word("infn", 32'h470, rd_val);
            reg_rd(8'h40);
            chk_word("unmapped", 32'h0, rd_val);
            reg_wr(`CFGIO_OUTFN_OFS, 32'h1111);
            src_v <= 7'h01;
            cycles(3);
            for (k = 0; k < 4; k++) chk_bit("alarm_output", 1'(k < 2 || i == 0), dout[k]);
            src_v <= 7'h00;
            $display("test strap %0d done", i);
        end
        do_reset(1'b0);
        reg_wr(`CFGIO_CFG_OFS, 32'h7);
        chk_bit("mains_60hz", 1'b1, mains_60hz_out);
        reg_wr(`CFGIO_CFG_OFS, 32'h3);
        chk_bit("mains_60hz", 1'b0, mains_60hz_out);
        $display("test mains done");
        reg_wr(`CFGIO_IRQ_EN_OFS, 32'h1);
        @(posedge ref_clk_in);
        pv_in_range_in <= 1'b1;
        cycles(3);
        chk_bit("rise_complete", 1'b1, rise_complete_out);
        chk_bit("irq", 1'b1, irq_out);
        @(posedge ref_clk_in);
        pv_in_range_in <= 1'b0;
        cycles(3);
        chk_bit("rise_complete", 1'b1, rise_complete_out);
        reg_wr(`CFGIO_IRQ_CLR_OFS, 32'hf);
        cycles(2);
        chk_bit("irq", 1'b0, irq_out);
        // completion flag held high here, so code 5 must show it
        for (i = 0; i < 10; i++) begin
            @(posedge ref_clk_in);
            src_v <= 7'($random(seed));
            reg_wr(`CFGIO_OUTFN_OFS, 32'(i));
            cycles(2);
            chk_bit("alarm_output_1", exp_out(4'(i), src_v, 1'b1), dout[0]);
        end
        reg_wr(`CFGIO_CFG_OFS, 32'h1);
        cycles(2);
        chk_bit("rise_complete", 1'b0, rise_complete_out);
        // a restart outranks an in-range measurement
        @(posedge ref_clk_in);
        pv_in_range_in  <= 1'b1;
        rise_restart_in <= 1'b1;
        cycles(2);
        chk_bit("rise_complete", 1'b0, rise_complete_out);
        rise_restart_in <= 1'b0;
        pv_in_range_in  <= 1'b0;
        $display("test outputs and completion done");
        for (i = 0; i < 2; i++) begin
            reg_wr(`CFGIO_GAP_OFS, 32'(i * 3));
            @(posedge ref_clk_in);
            rx_end_in <= 1'b1;
            @(posedge ref_clk_in);
            rx_end_in <= 1'b0;
            #1;
            n = 0;
            while (tx_permit_out !== 1'b1 && n < 100) begin
                cycles(1);
                n++;
            end
            if (n >= 100) begin
                error_cnt++;
                $display("Error tx_permit expected 1 seen timeout");
                complete_run();
            end
            chk_word("gap_cycles", 32'(i * 3 * MS_CYC), 32'(n));
        end
        $display("test gap done");
        reg_wr(`CFGIO_AREA_OFS, 32'h4);
        cycles(2);
        chk_word("area", 32'h5, 32'(memory_area_out));
        // with no input function, software owns run
        reg_wr(`CFGIO_CTRL_OFS, 32'h1);
        chk_bit("run_state", 1'b1, run_state_out);
        reg_rd(`CFGIO_STATUS_OFS);
        chk_word("status", 32'h1051, rd_val);
        reg_rd(`CFGIO_IRQ_STAT_OFS);
        chk_word("irq_stat", 32'h6, rd_val);
        reg_wr(`CFGIO_INFN_OFS, 32'h471);
        for (i = 0; i < 6; i++) begin
            n = (i == 0) ? 7 : (i == 1) ? 0 : ($random(seed) & 7);
            set_contacts(3'(n));
            chk_word("area", 32'(n + 1), 32'(memory_area_out));
        end
        reg_wr(`CFGIO_INFN_OFS, 32'h451);
        set_contacts(3'h7);
        chk_word("area", 32'h6, 32'(memory_area_out));
        reg_wr(`CFGIO_INFN_OFS, 32'h472);
        set_contacts(3'h1);
        chk_bit("run_state", 1'b1, run_state_out);
        chk_word("area", 32'h1, 32'(memory_area_out));
        set_contacts(3'h6);
        chk_bit("run_state", 1'b0, run_state_out);
        chk_word("area", 32'h4, 32'(memory_area_out));
        reg_wr(`CFGIO_INFN_OFS, 32'h473);
        set_contacts(3'h0);
        set_contacts(3'h2);
        chk_word("interlock_pulses", 32'h1, 32'(pulses));
        chk_word("area", 32'h1, 32'(memory_area_out));
        set_contacts(3'h5);
        chk_bit("run_state", 1'b1, run_state_out);
        chk_word("area", 32'h2, 32'(memory_area_out));
        $display("test contacts done");
        complete_run();
    end
endmodule // cfgio_core_tb
`default_nettype wire
